// ### src/csb_exec.sv
// Execution unit for compares, bit test-and-skip and conditional relative branches.
// Assumes operands, I/O bit value and the next instruction's length arrive from same-clock logic.
//
// Summary of operation
// (RULE_01) Compare with carry forms Rd minus Rr minus C, stores nothing, and sets Z, N, V, C, H in one cycle.
// (RULE_02) Compare immediate forms Rd minus K, discards it, and sets Z, N, V, C, H in one cycle.
// (RULE_03) Plain compare forms Rd minus Rr, discards it, and sets Z, N, V, C, H in one cycle.
// (RULE_04) Skip on register bit clear advances the PC by 2 or 3 when the bit is 0 and keeps the flags.
// (RULE_05) Skip on register bit set advances the PC by 2 or 3 when the bit is 1 and keeps the flags.
// (RULE_06) Skip on I/O bit clear advances the PC by 2 or 3 when the I/O bit reads 0.
// (RULE_07) Skip on I/O bit set advances the PC by 2 or 3 when the I/O bit reads 1, flags untouched.
// (RULE_08) Every test-and-skip takes one, two or three cycles depending on skip and skipped length.
// (RULE_09) A skip adds 2 over a one-word and 3 over a two-word instruction, taking 2 or 3 cycles.
// (RULE_10) Branch on flag set jumps to PC plus offset plus 1 when the selected status bit is 1.
// (RULE_11) Branch on flag clear jumps to PC plus offset plus 1 when the selected status bit is 0.
// (RULE_12) Branch on equal jumps when Z is 1.
// (RULE_13) Branch on carry clear jumps when C is 0.
// (RULE_14) Branch on same or higher jumps when C is 0, exactly like carry clear.
// (RULE_15) Branch on minus jumps when N is 1.
// (RULE_16) Conditional branches keep all flags and take one or two cycles.
// (RULE_17) A branch not taken takes one cycle, a taken one two cycles.
`timescale 1ns/100ps
module csb_exec
   import csb_pkg::*;
#(
   parameter int unsigned PC_WIDTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic opValid,
   input wire csb_op_t opCode,
   input wire logic [7:0] destVal,
   input wire logic [7:0] srcVal,
   input wire logic [7:0] immVal,
   input wire logic [2:0] bitSel,
   input wire logic ioBitVal,
   input wire logic signed [6:0] branchOffset,
   input wire logic nextIsTwoWord,
   input wire logic flagsLoad,
   input wire logic [7:0] flagsLoadVal,
   output logic [7:0] flagsQ,
   output logic [PC_WIDTH-1:0] pcQ,
   output logic busyQ,
   output logic doneQ,
   output logic jumpTakenQ
);

   typedef enum logic {ST_IDLE, ST_WAIT} csb_state_t;

   csb_state_t state_q;
   logic [1:0] remain_q;
   logic [PC_WIDTH-1:0] pcTarget_q;
   logic jumpPend_q;

   logic issue;
   logic isCompare;
   logic [7:0] subB;
   logic carryIn;
   logic [8:0] diff;
   logic [4:0] diffLow;
   logic [7:0] res;
   logic [7:0] cmpFlags;
   logic testBit;
   logic cond;
   logic isSkip;
   logic [1:0] cycles;
   logic [PC_WIDTH-1:0] pcNext;
   logic [PC_WIDTH-1:0] offsetExt;

   // New work is accepted only while idle
   assign issue = opValid && (state_q == ST_IDLE);

   // Shared subtractor for all three compares; immediate replaces Rr
   always_comb begin
      isCompare = (opCode == compare_regs_op) || (opCode == compare_regs_carry_op) ||
                  (opCode == compare_immediate_op);
      subB = (opCode == compare_immediate_op) ? immVal : srcVal; // RULE_02
      carryIn = (opCode == compare_regs_carry_op) ? flagsQ[FLAG_C] : 1'b0; // RULE_01
      diff = {1'b0, destVal} - {1'b0, subB} - {8'h00, carryIn}; // RULE_03
      diffLow = {1'b0, destVal[3:0]} - {1'b0, subB[3:0]} - {4'h0, carryIn};
      res = diff[7:0];
   end

   // Flag values from the difference; the result itself is never stored
   always_comb begin
      cmpFlags = flagsQ;
      cmpFlags[FLAG_C] = diff[8];
      cmpFlags[FLAG_H] = diffLow[4];
      cmpFlags[FLAG_N] = res[7];
      cmpFlags[FLAG_V] = (destVal[7] & ~subB[7] & ~res[7]) | (~destVal[7] & subB[7] & res[7]);
      cmpFlags[FLAG_S] = res[7] ^ cmpFlags[FLAG_V];
      // Carry form keeps Z only if it was already set, so multi-byte compares chain
      if (opCode == compare_regs_carry_op) begin
         cmpFlags[FLAG_Z] = (res == 8'h00) && flagsQ[FLAG_Z]; // RULE_01
      end else begin
         cmpFlags[FLAG_Z] = (res == 8'h00); // RULE_02 RULE_03
      end
   end

   // Skip and branch condition selection
   always_comb begin
      testBit = destVal[bitSel];
      isSkip = 1'b0;
      cond = 1'b0;
      unique case (opCode)
         skip_reg_bit_clear_op: begin
            isSkip = 1'b1;
            cond = ~testBit; // RULE_04
         end
         skip_reg_bit_set_op: begin
            isSkip = 1'b1;
            cond = testBit; // RULE_05
         end
         skip_io_bit_clear_op: begin
            isSkip = 1'b1;
            cond = ~ioBitVal; // RULE_06
         end
         skip_io_bit_set_op: begin
            isSkip = 1'b1;
            cond = ioBitVal; // RULE_07
         end
         branch_flag_set_op: cond = flagsQ[bitSel]; // RULE_10
         branch_flag_clear_op: cond = ~flagsQ[bitSel]; // RULE_11
         branch_equal_op: cond = flagsQ[FLAG_Z]; // RULE_12
         branch_carry_clear_op: cond = ~flagsQ[FLAG_C]; // RULE_13
         branch_same_or_higher_op: cond = ~flagsQ[FLAG_C]; // RULE_14
         branch_minus_op: cond = flagsQ[FLAG_N]; // RULE_15
         compare_regs_op, compare_regs_carry_op, compare_immediate_op: cond = 1'b0;
      endcase
   end

   // Next PC and cycle count for the issued operation
   always_comb begin
      offsetExt = PC_WIDTH'(signed'(branchOffset));
      pcNext = pcQ + PC_WIDTH'(PC_STEP_NEXT);
      cycles = CYC_ONE;
      if (isSkip && cond) begin
         if (nextIsTwoWord) begin
            pcNext = pcQ + PC_WIDTH'(PC_STEP_SKIP_TWO); // RULE_09
            cycles = CYC_THREE; // RULE_08
         end else begin
            pcNext = pcQ + PC_WIDTH'(PC_STEP_SKIP_ONE); // RULE_09
            cycles = CYC_TWO; // RULE_08
         end
      end else if (!isSkip && !isCompare && cond) begin
         pcNext = pcQ + offsetExt + PC_WIDTH'(PC_STEP_NEXT); // RULE_10 RULE_11
         cycles = CYC_TWO; // RULE_17
      end
   end

   // Sequencer: one-cycle work finishes at issue, longer work waits out its count
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         remain_q <= 2'h0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (issue && cycles != CYC_ONE) begin
                  state_q <= ST_WAIT;
                  remain_q <= cycles - CYC_ONE - CYC_ONE; // RULE_08 RULE_16
               end
            end
            ST_WAIT: begin
               if (remain_q == 2'h0) begin
                  state_q <= ST_IDLE;
               end else begin
                  remain_q <= remain_q - 2'h1;
               end
            end
         endcase
      end
   end

   // Pending PC target, committed when the operation completes
   always_ff @(posedge clk) begin
      if (reset) begin
         pcTarget_q <= PC_RESET[PC_WIDTH-1:0];
         jumpPend_q <= 1'b0;
      end else if (issue) begin
         pcTarget_q <= pcNext;
         jumpPend_q <= cond;
      end
   end

   // Program counter, done pulse and taken indication
   always_ff @(posedge clk) begin
      if (reset) begin
         pcQ <= PC_RESET[PC_WIDTH-1:0];
         doneQ <= 1'b0;
         jumpTakenQ <= 1'b0;
      end else begin
         doneQ <= 1'b0;
         if (issue && cycles == CYC_ONE) begin
            pcQ <= pcNext;
            doneQ <= 1'b1;
            jumpTakenQ <= 1'b0;
         end else if (state_q == ST_WAIT && remain_q == 2'h0) begin
            pcQ <= pcTarget_q;
            doneQ <= 1'b1;
            jumpTakenQ <= jumpPend_q;
         end
      end
   end

   // Busy mirrors the wait state, registered so the port comes from a flop
   always_ff @(posedge clk) begin
      if (reset) begin
         busyQ <= 1'b0;
      end else if (issue && cycles != CYC_ONE) begin
         busyQ <= 1'b1;
      end else if (state_q == ST_WAIT && remain_q == 2'h0) begin
         busyQ <= 1'b0;
      end
   end

   // Only compares and the side load write flags, a compare winning; skips and branches leave them alone
   always_ff @(posedge clk) begin
      if (reset) begin
         flagsQ <= FLAGS_RESET;
      end else if (issue && isCompare) begin
         flagsQ <= cmpFlags; // RULE_01 RULE_02 RULE_03
      end else if (flagsLoad) begin
         flagsQ <= flagsLoadVal; // RULE_16
      end
   end

endmodule

// ### src/csb_pkg.sv
// Constants and types shared by the compare, skip and branch execution unit.
// Assumes one clock domain and a fetch stage that supplies operands in the issue cycle.
package csb_pkg;

   // Operations handled by this unit
   typedef enum logic [3:0] {
      compare_regs_op,
      compare_regs_carry_op,
      compare_immediate_op,
      skip_reg_bit_clear_op,
      skip_reg_bit_set_op,
      skip_io_bit_clear_op,
      skip_io_bit_set_op,
      branch_flag_set_op,
      branch_flag_clear_op,
      branch_equal_op,
      branch_carry_clear_op,
      branch_same_or_higher_op,
      branch_minus_op
   } csb_op_t;

   // Bit positions in the status flags register
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;

   // Values after reset
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;

   // Cycle counts
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // Program counter steps, in words
   localparam logic [1:0] PC_STEP_NEXT = 2'h1;
   localparam logic [1:0] PC_STEP_SKIP_ONE = 2'h2;
   localparam logic [1:0] PC_STEP_SKIP_TWO = 2'h3;

endpackage

// ### tb/csb_exec_checker.sv
// Port-level checker for the compare, skip and branch unit.
// Bound onto every csb_exec; sees its ports only.
`timescale 1ns/100ps
module csb_exec_checker
   import csb_pkg::*;
#(
   parameter int unsigned PC_WIDTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic opValid,
   input wire csb_op_t opCode,
   input wire logic nextIsTwoWord,
   input wire logic flagsLoad,
   input wire logic [7:0] flagsQ,
   input wire logic [PC_WIDTH-1:0] pcQ,
   input wire logic busyQ,
   input wire logic doneQ,
   input wire logic jumpTakenQ
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Accepted issue and operation groups
   logic iss, skp, br;
   assign iss = opValid && !busyQ;
   assign skp = opCode inside {[skip_reg_bit_clear_op:skip_io_bit_set_op]};
   assign br = opCode >= branch_flag_set_op;
   sequence s_fast; doneQ && !jumpTakenQ; endsequence
   property p_cmp; iss && opCode <= compare_immediate_op |=> s_fast and !busyQ; endproperty
   a_cmp: assert property (p_cmp) else $error("compare not done in one cycle");
   property p_cmp_pc; iss && opCode <= compare_immediate_op |=> pcQ == $past(pcQ) + 1'b1; endproperty
   a_cmp_pc: assert property (p_cmp_pc) else $error("compare pc step wrong");
   property p_skip_fl; iss && skp && !flagsLoad |=> $stable(flagsQ); endproperty
   a_skip_fl: assert property (p_skip_fl) else $error("skip changed flags");
   property p_br_fl; iss && br && !flagsLoad |=> $stable(flagsQ); endproperty
   a_br_fl: assert property (p_br_fl) else $error("branch changed flags");
   property p_br_cyc; iss && br |=> s_fast or (busyQ && !doneQ ##1 doneQ && jumpTakenQ); endproperty
   a_br_cyc: assert property (p_br_cyc) else $error("branch cycle count wrong");
   property p_skip1; iss && skp && !nextIsTwoWord |=> s_fast or (busyQ ##1 doneQ && jumpTakenQ); endproperty
   a_skip1: assert property (p_skip1) else $error("short skip timing wrong");
   property p_skip2; iss && skp && nextIsTwoWord |=> s_fast or (busyQ[*2] ##1 doneQ && jumpTakenQ); endproperty
   a_skip2: assert property (p_skip2) else $error("long skip timing wrong");
   property p_busy; busyQ |-> !doneQ ##[1:2] doneQ; endproperty
   a_busy: assert property (p_busy) else $error("busy without timely done");
   // Main scenarios reached
   c_br: cover property (iss && br ##1 busyQ);
   c_skip2: cover property (iss && skp && nextIsTwoWord ##1 busyQ[*2]);
   c_cpc: cover property (iss && opCode == compare_regs_carry_op);
endmodule
bind csb_exec csb_exec_checker #(.PC_WIDTH(PC_WIDTH)) i_chk (
   .clk(clk),
   .reset(reset),
   .opValid(opValid),
   .opCode(opCode),
   .nextIsTwoWord(nextIsTwoWord),
   .flagsLoad(flagsLoad),
   .flagsQ(flagsQ),
   .pcQ(pcQ),
   .busyQ(busyQ),
   .doneQ(doneQ),
   .jumpTakenQ(jumpTakenQ)
);

// ### tb/tb_csb_exec.sv
// Self-checking bench for the compare, skip and branch unit.
// Drives at falling edges; a monitor pops queued expectations on done.
`timescale 1ns/100ps
module tb_csb_exec;
   import csb_pkg::*;
   logic clk = 0, reset = 1, opValid = 0, ioBitVal = 0, nextIsTwoWord = 0, flagsLoad = 0;
   csb_op_t opCode = compare_regs_op;
   logic [7:0] destVal = 0, srcVal = 0, immVal = 0, flagsLoadVal = 0, flagsQ, fm = 0, dv;
   logic [2:0] bitSel = 0;
   logic signed [6:0] branchOffset = 0;
   logic [15:0] pcQ, pm = 0;
   logic busyQ, doneQ, jumpTakenQ;
   logic [24:0] q[$];
   int n_errors = 0, n_checks = 0, cyc = 0, seed = 19;
   always #2 clk = ~clk;
   csb_exec i_dut (
      .clk(clk),
      .reset(reset),
      .opValid(opValid),
      .opCode(opCode),
      .destVal(destVal),
      .srcVal(srcVal),
      .immVal(immVal),
      .bitSel(bitSel),
      .ioBitVal(ioBitVal),
      .branchOffset(branchOffset),
      .nextIsTwoWord(nextIsTwoWord),
      .flagsLoad(flagsLoad),
      .flagsLoadVal(flagsLoadVal),
      .flagsQ(flagsQ),
      .pcQ(pcQ),
      .busyQ(busyQ),
      .doneQ(doneQ),
      .jumpTakenQ(jumpTakenQ)
   );
   task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Monitor at the falling edge, where outputs have settled; also cuts a hang short
   always @(negedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         n_errors++;
         conclude();
      end else if (!reset && doneQ !== 1'b0) begin
         if (q.size() == 0) chk(25'h0, 25'h1FFFFFF);
         else chk({flagsQ, pcQ, jumpTakenQ}, q.pop_front());
      end
   end
   // Flag setup through the side load, idle cycle
   task automatic ld(input logic [7:0] v);
      opValid = 0;
      flagsLoad = 1;
      flagsLoadVal = v;
      fm = v;
      @(negedge clk);
      flagsLoad = 0;
   endtask
   // Issue one op and predict it; opValid stays up while busy to probe refusal
   task automatic issue(input csb_op_t op, input logic [7:0] d, input logic [7:0] s,
                        input logic [2:0] b, input logic io, input logic tw);
      logic t, ci, v;
      logic [8:0] r;
      logic [4:0] h;
      opValid = 1;
      opCode = op;
      destVal = d;
      srcVal = s;
      immVal = s;
      bitSel = b;
      ioBitVal = io;
      nextIsTwoWord = tw;
      branchOffset = 7'($random(seed));
      t = 0;
      if (op <= compare_immediate_op) begin
         ci = (op == compare_regs_carry_op) ? fm[0] : 1'b0;
         r = {1'b0, d} - s - ci;
         h = {1'b0, d[3:0]} - s[3:0] - ci;
         v = (d[7] ^ s[7]) & (d[7] ^ r[7]);
         fm = {fm[7:6], h[4], r[7] ^ v, v, r[7], r[7:0] == 0 && (op != compare_regs_carry_op || fm[1]), r[8]};
      end
      else if (op <= skip_io_bit_set_op) t = op == skip_reg_bit_clear_op ? !d[b] : op == skip_reg_bit_set_op ? d[b]
         : op == skip_io_bit_clear_op ? !io : io;
      else t = op == branch_flag_set_op ? fm[b] : op == branch_flag_clear_op ? !fm[b]
         : op == branch_equal_op ? fm[1] : op == branch_minus_op ? fm[2] : !fm[0];
      if (op >= branch_flag_set_op) pm = pm + 16'h1 + (t ? {{9{branchOffset[6]}}, branchOffset} : 16'h0);
      else pm = pm + 16'h1 + (t ? 16'h1 + 16'(tw) : 16'h0);
      q.push_back({fm, pm, t});
      @(negedge clk);
      while (busyQ) @(negedge clk);
   endtask
   initial begin
      repeat (5) @(negedge clk);
      reset = 0;
      // Compares on random flags, every fourth pair equal
      for (int i = 0; i < 24; i++) begin
         ld(8'($random(seed)));
         dv = 8'($random(seed));
         issue(csb_op_t'(i % 3), dv, i[1:0] == 0 ? dv : 8'($random(seed)), 3'h0, 1'b0, 1'b0);
      end
      $display("compares done");
      // All four skips, both lengths, back to back
      for (int i = 0; i < 32; i++) issue(csb_op_t'(3 + i % 4), 8'($random(seed)), 8'h0, 3'($random(seed)),
         1'($random(seed)), i[2]);
      $display("skips done");
      // All six branches on fresh flags
      for (int i = 0; i < 36; i++) begin
         if (i % 6 == 0) ld(8'($random(seed)));
         issue(csb_op_t'(7 + i % 6), 8'h0, 8'h0, 3'($random(seed)), 1'b0, 1'b0);
      end
      opValid = 0;
      repeat (3) @(negedge clk);
      $display("branches done");
      chk(25'(q.size()), 25'h0);
      conclude();
   end
endmodule
